/* File: common/rcl_pkg.sv */
// Shared constants for the reset-time configuration loader
package rcl_pkg;

  // ------------------------------------------------------------
  // Flash addresses and widths
  // ------------------------------------------------------------
  localparam int                ADDR_W         = 23;             // Global flash address width
  localparam logic [22:0]       OPT_ADDR       = 23'h7fff0e;     // Option byte location
  localparam logic [22:0]       WAKE_TRIM_ADDR = 23'h4000f0;     // Info-row wakeup trim location
  localparam logic [22:0]       HOT_TRIM_ADDR  = 23'h4000f1;     // Hot trim location
  localparam logic [22:0]       FCFG_ADDR      = 23'h7fff0f;     // Flash module config byte

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int                OPT_RATE_LSB   = 0;              // Option rate bits [2:0]
  localparam int                OPT_WIN_BIT    = 3;              // Option window bit
  localparam int                WAKE_TRIM_W    = 6;              // Wakeup trim width
  localparam int                HOT_TRIM_W     = 4;              // Hot trim width
  localparam logic [2:0]        RATE_LONGEST   = 3'h7;           // Longest watchdog period
  localparam logic [7:0]        OPT_RST        = 8'hff;          // Option register reset value
  localparam logic [7:0]        FCFG_RST       = 8'h00;          // Flash config reset value
  localparam logic [5:0]        WAKE_TRIM_RST  = 6'h00;          // Wakeup trim reset value
  localparam logic [3:0]        HOT_TRIM_RST   = 4'h0;           // Hot trim reset value
  localparam logic [3:0]        HOT_TRIM_REC   = 4'h8;           // Value flash should hold

  // ------------------------------------------------------------
  // Sequence states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RCL_FCFG, RCL_OPT, RCL_WAKE, RCL_HOT, RCL_DONE
  } rcl_state_t;

endpackage

/* File: design/rcl_fetch.sv */
// One-byte flash read engine with fault reporting
`timescale 1ns/100ps
module rcl_fetch (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Request side
  input  wire logic                  req,
  input  wire logic [22:0]           addr,
  output logic                       done,
  output logic [7:0]                 data,
  output logic                       fault,
  // Flash array side
  output logic                       fl_rd,
  output logic [22:0]                fl_addr,
  input  wire logic                  fl_valid,
  input  wire logic [7:0]            fl_data,
  input  wire logic                  fl_dbl_fault
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic                              busy_reg,  busy_next;   // Read outstanding

  // Next-state computation
  always_comb begin
    busy_next  = busy_reg;
    if (busy_reg && fl_valid) begin
      busy_next  = 1'b0;
    end else if (!busy_reg && req) begin
      busy_next = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_reg  <= 1'b0;
    end else begin
      busy_reg  <= busy_next;
    end
  end

  // Outputs; byte and fault pass straight through, the requester
  // captures them in the done cycle so no extra stage is spent here
  assign fl_rd   = busy_reg;
  assign fl_addr = addr;
  assign done    = busy_reg && fl_valid;
  assign data    = fl_data;
  assign fault   = fl_dbl_fault;

endmodule // rcl_fetch

/* File: design/rcl_loader.sv */
// Reset-time configuration loader top
// Functional notes
// - Stall processor until all four flash bytes copied
// - Double faults leave protection and security active
// - Reset aborts running program or erase
// - Reset never clears RAM arrays
// - Option register loaded from fixed address
// - Watchdog rate is inverted option rate
// - Window bit is inverted option bit
// - Secured special single chip forces longest
// - Wakeup trim from six info-row bits
// - Reserved regulator space reads zero, no abort
// - Hot trim loaded from flash
`timescale 1ns/100ps
module rcl_loader (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Mode and security inputs
  input  wire logic                  secured,
  input  wire logic                  special_single_chip,
  // Processor stall
  output logic                       cpu_hold,
  output logic                       load_done,
  // Flash array read port
  output logic                       fl_rd,
  output logic [22:0]                fl_addr,
  input  wire logic                  fl_valid,
  input  wire logic [7:0]            fl_data,
  input  wire logic                  fl_dbl_fault,
  // Flash command control
  input  wire logic                  fl_cmd_active,
  output logic                       fl_cmd_abort,
  // Loaded configuration
  output logic [7:0]                 flash_option_reg,
  output logic [7:0]                 flash_config_reg,
  output logic [2:0]                 watchdog_rate_bits,
  output logic                       watchdog_window_bit,
  output logic [5:0]                 wakeup_trim_reg,
  output logic [3:0]                 hot_trim_field,
  output logic                       protect_forced,
  output logic                       security_forced,
  // Reserved regulator register space
  input  wire logic                  rsv_sel,
  input  wire logic                  rsv_wr,
  input  wire logic [7:0]            rsv_wdata,
  output logic [7:0]                 rsv_rdata,
  output logic                       rsv_abort
);

  // ------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------
  rcl_pkg::rcl_state_t               st_reg, st_next;        // Sequence state
  logic                              req_reg, req_next;      // Fetch request pending
  logic [7:0]                        opt_reg, opt_next;      // Option byte copy
  logic [7:0]                        fcfg_reg, fcfg_next;    // Flash config copy
  logic [5:0]                        wake_reg, wake_next;    // Wakeup trim
  logic [3:0]                        hot_reg, hot_next;      // Hot trim
  logic [2:0]                        rate_reg, rate_next;    // Watchdog rate
  logic                              win_reg, win_next;      // Window bit
  logic                              dflt_reg, dflt_next;    // Double fault seen
  logic                              abort_reg, abort_next;  // Abort pulse pending
  logic [22:0]                       cur_addr;               // Address of step
  logic                              f_done;                 // Fetch complete
  logic [7:0]                        f_data;                 // Fetched byte
  logic                              f_fault;                // Fetched fault

  // ------------------------------------------------------------
  // Fetch engine
  // ------------------------------------------------------------
  rcl_fetch u_fetch (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .req          (req_reg),
    .addr         (cur_addr),
    .done         (f_done),
    .data         (f_data),
    .fault        (f_fault),
    .fl_rd        (fl_rd),
    .fl_addr      (fl_addr),
    .fl_valid     (fl_valid),
    .fl_data      (fl_data),
    .fl_dbl_fault (fl_dbl_fault)
  );

  // Address per step, in fixed order
  always_comb begin
    case (st_reg)
      rcl_pkg::RCL_FCFG: cur_addr = rcl_pkg::FCFG_ADDR;
      rcl_pkg::RCL_OPT:  cur_addr = rcl_pkg::OPT_ADDR;
      rcl_pkg::RCL_WAKE: cur_addr = rcl_pkg::WAKE_TRIM_ADDR;
      rcl_pkg::RCL_HOT:  cur_addr = rcl_pkg::HOT_TRIM_ADDR;
      default:           cur_addr = rcl_pkg::FCFG_ADDR;
    endcase
  end

  // ------------------------------------------------------------
  // Sequence next-state logic
  // ------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    req_next   = 1'b0;
    opt_next   = opt_reg;
    fcfg_next  = fcfg_reg;
    wake_next  = wake_reg;
    hot_next   = hot_reg;
    rate_next  = rate_reg;
    win_next   = win_reg;
    dflt_next  = dflt_reg;
    abort_next = 1'b0;
    // Request issued one cycle after entering a loading state
    if (st_reg != rcl_pkg::RCL_DONE && !req_reg && !fl_rd) begin
      req_next = 1'b1;
    end
    if (f_done) begin
      // Any double fault sticks until next reset
      if (f_fault) begin
        dflt_next = 1'b1;
      end
      case (st_reg)
        rcl_pkg::RCL_FCFG: begin
          fcfg_next = f_data;
          st_next   = rcl_pkg::RCL_OPT;
        end
        rcl_pkg::RCL_OPT: begin
          opt_next  = f_data;
          rate_next = ~f_data[rcl_pkg::OPT_RATE_LSB +: 3];
          win_next  = ~f_data[rcl_pkg::OPT_WIN_BIT];
          if (secured && special_single_chip) begin
            rate_next = rcl_pkg::RATE_LONGEST;
          end
          st_next = rcl_pkg::RCL_WAKE;
        end
        rcl_pkg::RCL_WAKE: begin
          wake_next = f_data[rcl_pkg::WAKE_TRIM_W-1:0];
          st_next   = rcl_pkg::RCL_HOT;
        end
        rcl_pkg::RCL_HOT: begin
          hot_next = f_data[rcl_pkg::HOT_TRIM_W-1:0];
          st_next  = rcl_pkg::RCL_DONE;
        end
        default: begin
          st_next = rcl_pkg::RCL_DONE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sequence registers; RAM is never touched by this block
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg    <= rcl_pkg::RCL_FCFG;
      req_reg   <= 1'b0;
      opt_reg   <= rcl_pkg::OPT_RST;
      fcfg_reg  <= rcl_pkg::FCFG_RST;
      wake_reg  <= rcl_pkg::WAKE_TRIM_RST;
      hot_reg   <= rcl_pkg::HOT_TRIM_RST;
      rate_reg  <= rcl_pkg::RATE_LONGEST;
      win_reg   <= 1'b0;
      dflt_reg  <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      req_reg   <= req_next;
      opt_reg   <= opt_next;
      fcfg_reg  <= fcfg_next;
      wake_reg  <= wake_next;
      hot_reg   <= hot_next;
      rate_reg  <= rate_next;
      win_reg   <= win_next;
      dflt_reg  <= dflt_next;
      abort_reg <= abort_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Hold processor until sequence done
  assign cpu_hold            = (st_reg != rcl_pkg::RCL_DONE);
  assign load_done           = (st_reg == rcl_pkg::RCL_DONE);
  // Abort is immediate: reset itself kills the running command
  assign fl_cmd_abort        = rst & fl_cmd_active;
  assign flash_option_reg    = opt_reg;
  assign flash_config_reg    = fcfg_reg;
  assign watchdog_rate_bits  = rate_reg;
  assign watchdog_window_bit = win_reg;
  assign wakeup_trim_reg     = wake_reg;
  assign hot_trim_field      = hot_reg;
  assign protect_forced      = dflt_reg;
  assign security_forced     = dflt_reg;
  // Reserved space: zero read, writes dropped, never aborts
  assign rsv_rdata           = 8'h00;
  assign rsv_abort           = 1'b0;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Stall may only drop right after the last copy completes
  property p_hold_until_done;
    @(posedge ref_clk) disable iff (rst)
      (!cpu_hold) |-> ($past(!cpu_hold) || $past(st_reg == rcl_pkg::RCL_HOT && f_done));
  endproperty
  a_hold_until_done: assert property (p_hold_until_done) else $error("hold dropped early");

  property p_order;
    @(posedge ref_clk) disable iff (rst)
      (st_reg == rcl_pkg::RCL_OPT && f_done) |=> (st_reg == rcl_pkg::RCL_WAKE);
  endproperty
  a_order: assert property (p_order) else $error("sequence order broken");

  property p_rate_inv;
    @(posedge ref_clk) disable iff (rst)
      (st_reg == rcl_pkg::RCL_OPT && f_done && !(secured && special_single_chip))
      |=> (watchdog_rate_bits == ~$past(fl_data[2:0]));
  endproperty
  a_rate_inv: assert property (p_rate_inv) else $error("rate not inverted");

  property p_win_inv;
    @(posedge ref_clk) disable iff (rst)
      (st_reg == rcl_pkg::RCL_OPT && f_done) |=> (watchdog_window_bit == !flash_option_reg[3]);
  endproperty
  a_win_inv: assert property (p_win_inv) else $error("window bit wrong");

  property p_secure_rate;
    @(posedge ref_clk) disable iff (rst)
      (st_reg == rcl_pkg::RCL_OPT && f_done && secured && special_single_chip)
      |=> (watchdog_rate_bits == 3'h7);
  endproperty
  a_secure_rate: assert property (p_secure_rate) else $error("secure rate not longest");

  property p_opt_addr;
    @(posedge ref_clk) disable iff (rst)
      (fl_rd && st_reg == rcl_pkg::RCL_OPT) |-> (fl_addr == 23'h7fff0e);
  endproperty
  a_opt_addr: assert property (p_opt_addr) else $error("option address wrong");

  property p_wake_load;
    @(posedge ref_clk) disable iff (rst)
      (st_reg == rcl_pkg::RCL_WAKE && f_done) |=> (wakeup_trim_reg == $past(fl_data[5:0]));
  endproperty
  a_wake_load: assert property (p_wake_load) else $error("wakeup trim wrong");

  property p_hot_load;
    @(posedge ref_clk) disable iff (rst)
      (st_reg == rcl_pkg::RCL_HOT && f_done) |=> (hot_trim_field == $past(fl_data[3:0])) && !cpu_hold;
  endproperty
  a_hot_load: assert property (p_hot_load) else $error("hot trim wrong");

  property p_fault_sticky;
    @(posedge ref_clk) disable iff (rst)
      (f_done && f_fault) |=> (protect_forced && security_forced)[*2];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault not kept");

  property p_rsv;
    @(posedge ref_clk) disable iff (rst)
      (rsv_sel) |-> (rsv_rdata == 8'h00 && !rsv_abort);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved access misbehaved");

  // Writes into reserved space leave the loaded trims untouched
  property p_rsv_wr;
    @(posedge ref_clk) disable iff (rst)
      (load_done && rsv_sel && rsv_wr && (rsv_wdata != 8'h00))
      |=> (rsv_rdata == 8'h00 && $stable(hot_trim_field) && $stable(wakeup_trim_reg));
  endproperty
  a_rsv_wr: assert property (p_rsv_wr) else $error("reserved write had effect");

  c_done:   cover property (@(posedge ref_clk) disable iff (rst) $rose(load_done));
  c_fault:  cover property (@(posedge ref_clk) disable iff (rst) f_done && f_fault);
  c_secure: cover property (@(posedge ref_clk) disable iff (rst)
                            st_reg == rcl_pkg::RCL_OPT && f_done && secured && special_single_chip);

endmodule // rcl_loader

/* File: bench/rcl_flash_model.sv */
// Behavioural flash array answering the loader's reads
`timescale 1ns/100ps
module rcl_flash_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Read port
  input  wire logic        fl_rd,
  input  wire logic [22:0] fl_addr,
  output logic             fl_valid,
  output logic [7:0]       fl_data,
  output logic             fl_dbl_fault,
  // Scenario controls
  input  wire logic [7:0]  opt_byte,
  input  wire logic [3:0]  wait_cycles,
  input  wire logic        fault_en
);
  logic [3:0] cnt;  // Cycles waited on this read
  logic [7:0] word; // Byte stored at fl_addr

  // Stored contents
  always_comb begin
    case (fl_addr)
      rcl_pkg::OPT_ADDR:       word = opt_byte;
      rcl_pkg::WAKE_TRIM_ADDR: word = 8'hea;
      rcl_pkg::HOT_TRIM_ADDR:  word = 8'h58;
      rcl_pkg::FCFG_ADDR:      word = 8'ha5;
      default:                 word = 8'h3c;
    endcase
  end

  // Answer after wait_cycles; data toggles when not valid
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt          <= 4'h0;
      fl_valid     <= 1'b0;
      fl_data      <= 8'h00;
      fl_dbl_fault <= 1'b0;
    end else if (fl_rd && !fl_valid && cnt >= wait_cycles) begin
      cnt          <= 4'h0;
      fl_valid     <= 1'b1;
      fl_data      <= word;
      fl_dbl_fault <= fault_en && fl_addr == rcl_pkg::HOT_TRIM_ADDR;
    end else begin
      cnt          <= fl_rd ? cnt + 4'h1 : 4'h0;
      fl_valid     <= 1'b0;
      fl_data      <= ~fl_data;
      fl_dbl_fault <= 1'b0;
    end
  end
endmodule // rcl_flash_model

/* File: bench/tb.sv */
// Self-checking testbench for the reset-time configuration loader
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  logic        ref_clk, rst, secured, special_single_chip, fl_cmd_active;
  logic        rsv_sel, rsv_wr, fault_en;
  logic [7:0]  rsv_wdata, opt_byte;
  logic [3:0]  wait_cycles;
  logic        cpu_hold, load_done, fl_rd, fl_valid, fl_dbl_fault, fl_cmd_abort;
  logic [22:0] fl_addr;
  logic [7:0]  fl_data, flash_option_reg, flash_config_reg, rsv_rdata;
  logic [2:0]  watchdog_rate_bits;
  logic        watchdog_window_bit, protect_forced, security_forced, rsv_abort;
  logic [5:0]  wakeup_trim_reg;
  logic [3:0]  hot_trim_field;
  int          errors, tests_run;
  logic [22:0] seen[$]; // Addresses read since last release

  rcl_loader dut_u (.ref_clk(ref_clk), .rst(rst), .secured(secured),
    .special_single_chip(special_single_chip), .cpu_hold(cpu_hold), .load_done(load_done),
    .fl_rd(fl_rd), .fl_addr(fl_addr), .fl_valid(fl_valid), .fl_data(fl_data),
    .fl_dbl_fault(fl_dbl_fault), .fl_cmd_active(fl_cmd_active), .fl_cmd_abort(fl_cmd_abort),
    .flash_option_reg(flash_option_reg), .flash_config_reg(flash_config_reg),
    .watchdog_rate_bits(watchdog_rate_bits), .watchdog_window_bit(watchdog_window_bit),
    .wakeup_trim_reg(wakeup_trim_reg), .hot_trim_field(hot_trim_field),
    .protect_forced(protect_forced), .security_forced(security_forced), .rsv_sel(rsv_sel),
    .rsv_wr(rsv_wr), .rsv_wdata(rsv_wdata), .rsv_rdata(rsv_rdata), .rsv_abort(rsv_abort));

  rcl_flash_model flash_u (.ref_clk(ref_clk), .rst(rst), .fl_rd(fl_rd), .fl_addr(fl_addr),
    .fl_valid(fl_valid), .fl_data(fl_data), .fl_dbl_fault(fl_dbl_fault),
    .opt_byte(opt_byte), .wait_cycles(wait_cycles), .fault_en(fault_en));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Record completed reads in order
  always @(posedge ref_clk) begin
    if (!rst && fl_rd && fl_valid) seen.push_back(fl_addr);
  end

  // Processor stays stalled while any read is pending
  always @(negedge ref_clk) begin
    if (!rst && fl_rd) `CHK(cpu_hold, 1'b1)
  end

  // Print counts and verdict, then end
  task stop_test;
    $display("Counts: %0d checks, %0d errors", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hold reset 8 cycles, checking the held state
  task do_reset;
    @(negedge ref_clk) rst = 1'b1;
    @(negedge ref_clk);
    `CHK(fl_cmd_abort, fl_cmd_active)
    `CHK({cpu_hold, fl_rd, flash_option_reg}, {2'b10, rcl_pkg::OPT_RST})
    repeat (7) @(negedge ref_clk);
    seen.delete();
    rst = 1'b0;
  endtask

  // One full reset copy with given flash contents and mode
  task load(input logic [7:0] opt, input logic sec, ssc, flt, input logic [3:0] wt);
    int n;
    opt_byte = opt;
    secured = sec;
    special_single_chip = ssc;
    fault_en = flt;
    wait_cycles = wt;
    do_reset;
    n = 0;
    while (load_done !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(cpu_hold, 1'b0)
    `CHK(seen.size(), 4)
    `CHK({seen[0], seen[1], seen[2], seen[3]}, {rcl_pkg::FCFG_ADDR, rcl_pkg::OPT_ADDR,
      rcl_pkg::WAKE_TRIM_ADDR, rcl_pkg::HOT_TRIM_ADDR})
    `CHK(flash_option_reg, opt)
    `CHK(watchdog_rate_bits, (sec && ssc) ? rcl_pkg::RATE_LONGEST : ~opt[2:0])
    `CHK(watchdog_window_bit, ~opt[3])
    `CHK({protect_forced, security_forced}, {flt, flt})
    if (!flt) begin
      `CHK(flash_config_reg, 8'ha5)
      `CHK(wakeup_trim_reg, 6'h2a)
      `CHK(hot_trim_field, rcl_pkg::HOT_TRIM_REC)
    end
    $display("Test done: option %h sec %b ssc %b fault %b", opt, sec, ssc, flt);
  endtask

  // Reserved space access: reads zero, write ignored, no abort
  task rsv_access(input logic wr, input logic [7:0] d);
    @(negedge ref_clk);
    rsv_sel = 1'b1;
    rsv_wr = wr;
    rsv_wdata = d;
    @(negedge ref_clk);
    `CHK({rsv_rdata, rsv_abort}, 9'h000)
    rsv_sel = 1'b0;
    rsv_wr = 1'b0;
  endtask

  // Main sequence
  initial begin
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    {secured, special_single_chip, rsv_sel, rsv_wr, fault_en} = 5'h00;
    rsv_wdata = 8'h00;
    opt_byte = 8'h00;
    wait_cycles = 4'h0;
    fl_cmd_active = 1'b1;
    load(8'h00, 1'b0, 1'b0, 1'b0, 4'h0);
    `CHK(fl_cmd_abort, 1'b0)
    fl_cmd_active = 1'b0;
    for (int i = 0; i < 16; i++) load({4'ha, i[3:0]}, 1'b0, 1'b0, 1'b0, i[3:0] % 4'h3);
    load(8'h07, 1'b1, 1'b1, 1'b0, 4'h2);
    load(8'h05, 1'b1, 1'b0, 1'b0, 4'h0);
    load(8'h05, 1'b0, 1'b1, 1'b0, 4'h1);
    load(8'h0b, 1'b0, 1'b0, 1'b1, 4'h1);
    load(8'h0b, 1'b0, 1'b0, 1'b0, 4'h0);
    // Reset in mid-copy restarts the whole sequence
    wait_cycles = 4'h3;
    do_reset;
    repeat (6) @(negedge ref_clk);
    fl_cmd_active = 1'b1;
    load(8'h96, 1'b0, 1'b0, 1'b0, 4'h3);
    fl_cmd_active = 1'b0;
    rsv_access(1'b1, 8'hff);
    rsv_access(1'b0, 8'h00);
    `CHK(hot_trim_field, rcl_pkg::HOT_TRIM_REC)
    $display("Test done: reserved space");
    stop_test;
  end

  // Watchdog against a hung sequence
  initial begin
    #200000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule // tb
